// [ecp_fifo_dma_service.sv]
// ECP port FIFO service: host/DMA side, link sequencer, service interrupts.
// Assumes host strobes are synchronous to ref_clk_i; peripheral lines are not.
//
// What this block does
// - Forward link drives HostAck high for data bytes, low for command bytes.
// - Command bit 7 low means run-length count, high means channel address.
// - A run-length count N makes the next data byte appear N+1 times.
// - No compression is done in hardware; only expansion of given counts.
// - Four control lines are open-collector in mode 000, push-pull otherwise.
// - Mask bit set blocks every DMA request and every service interrupt.
// - Clearing the mask while a service condition holds interrupts at once.
// - Interrupt line pulses low briefly, then floats for sharing.
// - Terminal count with DMA enabled and unmasked interrupts and sets the mask.
// - Forward programmed I/O interrupts when write service level bytes are free.
// - Reverse programmed I/O interrupts when read service level bytes are held.
// - Enabled fault interrupt on nFault fall, or on enable falling while asserted.
// - Enabled acknowledge interrupt on each rising edge of nAck.
// - Effective threshold is field plus one; sixteen acts as fifteen.
// - FIFO is disabled after reset and used only in modes 010 and 011.
// - DMA request drops after 32 cycles until acknowledge idles 350 ns.
// - Reverse DMA requests while data is held; stops on empty or terminal count.
// - DMA cycles reach the FIFO on acknowledge alone, address ignored.
// - Data FIFO sits at offset 400H, address/run-length FIFO at 000H.
// - Mode 011 is ECP with automatic transfer, 010 the standard FIFO protocol.
// - Forward service condition holds when FIFO count is at most the threshold.
// - Reverse service condition holds when count is at least 16 minus threshold.
`timescale 1ns/1ns
module ecp_fifo_dma_service (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // Host programmed I/O
  input  wire logic [10:0] host_addr_i,
  input  wire logic        host_wr_i,
  input  wire logic        host_rd_i,
  input  wire logic [7:0]  host_wdata_i,
  output logic      [7:0]  host_rdata_o,
  output logic             host_wr_ready_o,
  // Host DMA
  output logic             dma_request_o,
  input  wire logic        dma_acknowledge_n_i,
  input  wire logic        dma_tc_i,
  // Control and status levels
  input  wire logic [2:0]  port_mode_i,
  input  wire logic        direction_i,
  input  wire logic        dma_enable_bit_i,
  input  wire logic        mask_wr_i,
  input  wire logic        mask_wdata_i,
  output logic             service_irq_mask_o,
  input  wire logic        fault_irq_enable_n_i,
  input  wire logic        ack_irq_enable_i,
  input  wire logic [3:0]  fifo_threshold_field_i,
  input  wire logic [3:0]  sw_ctl_lines_i,
  output logic             fifo_empty_o,
  output logic             fifo_full_o,
  // Interrupt line
  output logic             port_irq_out_o,
  output logic             port_irq_out_oe_o,
  // Peripheral link
  output logic      [7:0]  periph_data_o,
  output logic             periph_data_oe_o,
  input  wire logic [7:0]  periph_data_i,
  output logic      [3:0]  ctl_lines_o,
  output logic      [3:0]  ctl_lines_oe_o,
  input  wire logic [3:0]  ctl_lines_i,
  input  wire logic        periph_busy_i,
  input  wire logic        periph_ack_n_i,
  input  wire logic        periph_fault_n_i
);

  ecp_service_pkg::link_state_t state, next_state;

  logic [2:0] pins_s;
  logic       busy_s, ack_n_s, fault_n_s;
  logic [3:0] ctl_seen;

  logic       fifo_en, fwd, ecp_mode;
  logic       fin_valid, fin_ready, fout_valid, fout_ready;
  logic [8:0] fin_data, fout_data;
  logic [4:0] fcount;

  logic [7:0] tx_data, next_tx_data, rx_data, next_rx_data;
  logic       tx_cmd, next_tx_cmd, rx_cmd, next_rx_cmd;
  logic [6:0] rle_cnt, next_rle_cnt, rep, next_rep;
  logic       rle_pend, next_rle_pend;
  logic       tx_pop, rx_push;
  logic [3:0] next_ctl, next_ctl_oe;
  logic [7:0] next_rdata;

  logic       host_push, host_pop, host_cmd, dma_access, dma_cycle;
  logic       mask, next_mask, tc_event;
  logic [5:0] burst, next_burst;
  logic [4:0] gap, next_gap;
  logic       next_req;

  logic [4:0] thr_eff;
  logic       svc_cond, svc_prev, ack_prev, fault_prev, fen_prev;
  logic       irq_event;
  logic [2:0] irq_cnt, next_irq_cnt;

  // Busy, acknowledge and fault lines pass two flops before any use
  line_sync #(
    .W       (3),
    .RST_VAL (3'h6)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({periph_fault_n_i, periph_ack_n_i, periph_busy_i}),
    .sync_o    (pins_s)
  );
  assign busy_s    = pins_s[0];
  assign ack_n_s   = pins_s[1];
  assign fault_n_s = pins_s[2];

  assign fifo_en  = (port_mode_i == ecp_service_pkg::MODE_ECP) ||
                    (port_mode_i == ecp_service_pkg::MODE_FIFO);
  assign ecp_mode = (port_mode_i == ecp_service_pkg::MODE_ECP);
  assign fwd      = !direction_i;

  // Host access: DMA cycles decode on acknowledge only
  assign dma_access = !dma_acknowledge_n_i;
  assign host_cmd   = !dma_access && (host_addr_i == ecp_service_pkg::ADDR_PORT_OFS) && ecp_mode;
  assign host_push  = fifo_en && fwd && host_wr_i &&
                      (dma_access || host_cmd ||
                       host_addr_i == ecp_service_pkg::DATA_PORT_OFS);
  assign host_pop   = fifo_en && !fwd && host_rd_i &&
                      (dma_access || host_addr_i == ecp_service_pkg::DATA_PORT_OFS);
  assign dma_cycle  = dma_access && (host_wr_i || host_rd_i);

  assign fin_valid  = fwd ? host_push : rx_push;
  assign fin_data   = fwd ? {host_cmd, host_wdata_i} : {rx_cmd, rx_data};
  assign fout_ready = fwd ? tx_pop : host_pop;
  assign host_wr_ready_o = fwd && fin_ready;

  service_fifo #(
    .WIDTH (ecp_service_pkg::ENTRY_W),
    .DEPTH (ecp_service_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .clear_i     (!fifo_en),
    .in_valid_i  (fin_valid),
    .in_ready_o  (fin_ready),
    .in_data_i   (fin_data),
    .out_valid_o (fout_valid),
    .out_ready_i (fout_ready),
    .out_data_o  (fout_data),
    .count_o     (fcount)
  );
  assign fifo_empty_o = (fcount == '0);
  assign fifo_full_o  = (fcount == ecp_service_pkg::FIFO_FULL_CNT);

  // Link sequencer
  always_comb
  begin
    next_state    = state;
    next_tx_data  = tx_data;
    next_tx_cmd   = tx_cmd;
    next_rx_data  = rx_data;
    next_rx_cmd   = rx_cmd;
    next_rle_cnt  = rle_cnt;
    next_rle_pend = rle_pend;
    next_rep      = rep;
    tx_pop        = 1'b0;
    rx_push       = 1'b0;
    unique case (state)
      ecp_service_pkg::ST_IDLE:
      begin
        if (fifo_en && fwd && fout_valid)
        begin
          tx_pop = 1'b1;
          if (ecp_mode && fout_data[ecp_service_pkg::CMD_FLAG_BIT] &&
              !fout_data[ecp_service_pkg::CMD_TYPE_BIT])
          begin
            next_rle_cnt  = fout_data[6:0];
            next_rle_pend = 1'b1;
          end
          else
          begin
            next_tx_data = fout_data[7:0];
            next_tx_cmd  = fout_data[ecp_service_pkg::CMD_FLAG_BIT];
            next_rep     = (rle_pend && !next_tx_cmd) ? rle_cnt : '0;
            if (!next_tx_cmd)
              next_rle_pend = 1'b0;
            next_state = ecp_service_pkg::ST_FWD_SETUP;
          end
        end
        else if (fifo_en && !fwd && ecp_mode)
          next_state = ecp_service_pkg::ST_REV_WAIT;
      end
      ecp_service_pkg::ST_FWD_SETUP:
        next_state = ecp_service_pkg::ST_FWD_STRB;
      ecp_service_pkg::ST_FWD_STRB:
        if (busy_s)
          next_state = ecp_service_pkg::ST_FWD_REL;
      ecp_service_pkg::ST_FWD_REL:
        if (!busy_s)
        begin
          if (rep != '0)
          begin
            next_rep   = rep - 7'h01;
            next_state = ecp_service_pkg::ST_FWD_SETUP;
          end
          else
            next_state = ecp_service_pkg::ST_IDLE;
        end
      ecp_service_pkg::ST_REV_WAIT:
        if (!ack_n_s)
        begin
          next_rx_data = periph_data_i;
          next_rx_cmd  = !busy_s;
          next_state   = ecp_service_pkg::ST_REV_ACK;
        end
      ecp_service_pkg::ST_REV_ACK:
        if (ack_n_s)
        begin
          next_state = ecp_service_pkg::ST_REV_WAIT;
          if (rx_cmd && !rx_data[ecp_service_pkg::CMD_TYPE_BIT])
          begin
            next_rle_cnt  = rx_data[6:0];
            next_rle_pend = 1'b1;
          end
          else if (!rx_cmd)
          begin
            next_rep      = rle_pend ? rle_cnt : '0;
            next_rle_pend = 1'b0;
            next_state    = ecp_service_pkg::ST_REV_PUSH;
          end
        end
      ecp_service_pkg::ST_REV_PUSH:
      begin
        rx_push = 1'b1;
        if (fin_ready)
        begin
          if (rep == '0)
            next_state = ecp_service_pkg::ST_REV_WAIT;
          else
            next_rep = rep - 7'h01;
        end
      end
      default:
        next_state = ecp_service_pkg::ST_IDLE;
    endcase
    if (!fifo_en || (fwd && state[4]) || (!fwd && (state[1] || state[2] || state[3])))
      next_state = ecp_service_pkg::ST_IDLE;
  end

  // Line levels and drivers
  always_comb
  begin
    next_ctl = sw_ctl_lines_i;
    if (fifo_en)
      next_ctl[ecp_service_pkg::CTL_STROBE] = !(next_state == ecp_service_pkg::ST_FWD_STRB);
    if (ecp_mode)
      next_ctl[ecp_service_pkg::CTL_AUTOFD] = fwd ? !next_tx_cmd
                                              : (next_state == ecp_service_pkg::ST_REV_ACK);
    if (port_mode_i == ecp_service_pkg::MODE_SPP)
      next_ctl_oe = ~next_ctl;
    else
      next_ctl_oe = 4'hf;
    next_rdata = host_pop ? fout_data[7:0] : host_rdata_o;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      state            <= ecp_service_pkg::ST_IDLE;
      tx_data          <= '0;
      tx_cmd           <= 1'b0;
      rx_data          <= '0;
      rx_cmd           <= 1'b0;
      rle_cnt          <= '0;
      rle_pend         <= 1'b0;
      rep              <= '0;
      ctl_lines_o      <= 4'hf;
      ctl_lines_oe_o   <= 4'h0;
      ctl_seen         <= 4'hf;
      periph_data_o    <= '0;
      periph_data_oe_o <= 1'b0;
      host_rdata_o     <= '0;
    end
    else
    begin
      state            <= next_state;
      tx_data          <= next_tx_data;
      tx_cmd           <= next_tx_cmd;
      rx_data          <= next_rx_data;
      rx_cmd           <= next_rx_cmd;
      rle_cnt          <= next_rle_cnt;
      rle_pend         <= next_rle_pend;
      rep              <= next_rep;
      ctl_lines_o      <= next_ctl;
      ctl_lines_oe_o   <= next_ctl_oe;
      ctl_seen         <= ctl_lines_i;
      periph_data_o    <= next_tx_data;
      periph_data_oe_o <= !(direction_i && port_mode_i != ecp_service_pkg::MODE_SPP);
      host_rdata_o     <= next_rdata;
    end
  end

  // DMA request, burst limit and terminal count
  assign tc_event = dma_cycle && dma_tc_i && dma_enable_bit_i && !mask;
  always_comb
  begin
    next_mask = mask;
    if (mask_wr_i)
      next_mask = mask_wdata_i;
    if (tc_event)
      next_mask = 1'b1;
    next_burst = burst;
    next_gap   = gap;
    if (dma_cycle && burst != ecp_service_pkg::DMA_BURST_MAX)
      next_burst = burst + 6'h01;
    if (!dma_acknowledge_n_i)
      next_gap = '0;
    else if (gap != ecp_service_pkg::DACK_GAP_CNT)
      next_gap = gap + 5'h01;
    if (next_gap == ecp_service_pkg::DACK_GAP_CNT && !dma_request_o)
      next_burst = '0;
    next_req = fifo_en && dma_enable_bit_i && !next_mask &&
               next_burst != ecp_service_pkg::DMA_BURST_MAX &&
               (fwd ? (next_burst != '0 || next_gap == ecp_service_pkg::DACK_GAP_CNT ||
                       dma_request_o) && fcount + 5'(fin_valid && fin_ready)
                       < ecp_service_pkg::FIFO_FULL_CNT
                    : fcount > 5'(host_pop));
  end

  // Service threshold and interrupt events
  assign thr_eff  = (5'(fifo_threshold_field_i) + 5'h01 > ecp_service_pkg::THR_MAX_EFF)
                    ? ecp_service_pkg::THR_MAX_EFF
                    : 5'(fifo_threshold_field_i) + 5'h01;
  assign svc_cond = fifo_en && !mask && !dma_enable_bit_i &&
                    (fwd ? fcount <= thr_eff
                         : fcount >= ecp_service_pkg::FIFO_FULL_CNT - thr_eff);
  assign irq_event = (svc_cond && !svc_prev) ||
                     tc_event ||
                     (!fault_irq_enable_n_i && fault_prev && !fault_n_s) ||
                     (!fault_irq_enable_n_i && fen_prev && !fault_n_s) ||
                     (ack_irq_enable_i && !ack_prev && ack_n_s);
  always_comb
  begin
    next_irq_cnt = irq_cnt;
    if (irq_event)
      next_irq_cnt = ecp_service_pkg::IRQ_PULSE_CNT;
    else if (irq_cnt != '0)
      next_irq_cnt = irq_cnt - 3'h1;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      mask              <= ecp_service_pkg::MASK_RST_VAL;
      burst             <= '0;
      gap               <= ecp_service_pkg::DACK_GAP_CNT;
      dma_request_o     <= 1'b0;
      svc_prev          <= 1'b0;
      ack_prev          <= 1'b1;
      fault_prev        <= 1'b1;
      fen_prev          <= 1'b0;
      irq_cnt           <= '0;
      port_irq_out_o    <= 1'b0;
      port_irq_out_oe_o <= 1'b0;
    end
    else
    begin
      mask              <= next_mask;
      burst             <= next_burst;
      gap               <= next_gap;
      dma_request_o     <= next_req;
      svc_prev          <= svc_cond;
      ack_prev          <= ack_n_s;
      fault_prev        <= fault_n_s;
      fen_prev          <= fault_irq_enable_n_i;
      irq_cnt           <= next_irq_cnt;
      port_irq_out_o    <= 1'b0;
      port_irq_out_oe_o <= (next_irq_cnt != '0);
    end
  end
  assign service_irq_mask_o = mask;

endmodule : ecp_fifo_dma_service

// [ecp_periph_model.sv]
// Forward-channel ECP peripheral: takes a byte on each strobe, answers with busy.
// Assumes control lines arrive as resolved wire levels; hold_i stalls it.
`timescale 1ns/1ns
module ecp_periph_model (
  input  wire logic       ref_clk_i,
  input  wire logic       hold_i,
  input  wire logic [3:0] ctl_i,
  input  wire logic [7:0] data_i,
  output logic            busy_o,
  output logic      [7:0] last_o,
  output int              n_data_o,
  output int              n_cmd_o
);
  initial
  begin
    busy_o = 1'b0;
    last_o = 8'h00;
    n_data_o = 0;
    n_cmd_o = 0;
  end
  // Busy held up while stalled, so the sender cannot finish its cycle
  always @(posedge ref_clk_i)
    if (!busy_o && !ctl_i[0])
    begin
      busy_o <= 1'b1;
      last_o <= data_i;
      if (ctl_i[1]) n_data_o <= n_data_o + 1;
      else n_cmd_o <= n_cmd_o + 1;
    end
    else if (busy_o && ctl_i[0] && !hold_i)
      busy_o <= 1'b0;
endmodule : ecp_periph_model

// [ecp_service_monitor.sv]
// Port-level checks of the ECP FIFO service block.
// Assumes a bind from the bench; one clock, synchronous active-low reset.
`timescale 1ns/1ns
module ecp_service_monitor (
  // Clock and reset
  input wire logic       ref_clk_i, rst_n_i,
  // Host and DMA
  input wire logic       host_wr_i, host_rd_i, dma_request_o, dma_acknowledge_n_i, dma_tc_i,
  // Control and status
  input wire logic [2:0] port_mode_i,
  input wire logic       direction_i, dma_enable_bit_i, service_irq_mask_o, fifo_empty_o,
  input wire logic       fault_irq_enable_n_i, ack_irq_enable_i,
  // Lines
  input wire logic       periph_ack_n_i, periph_fault_n_i, port_irq_out_oe_o,
  input wire logic [3:0] ctl_lines_oe_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [5:0] burst;
  logic [5:0] next_burst;
  logic       dma_cyc;
  // Counts accesses only while the request stays up, so it never outruns the design
  always_comb
  begin
    dma_cyc    = !dma_acknowledge_n_i && (host_rd_i || host_wr_i);
    next_burst = dma_request_o ? burst + {5'h00, dma_cyc} : 6'h00;
  end
  always_ff @(posedge ref_clk_i)
    burst <= !rst_n_i ? 6'h00 : next_burst;
  sequence irq_pulse_s;
    port_irq_out_oe_o [*5];
  endsequence
  sequence tc_cycle_s;
    dma_cyc && dma_tc_i && dma_enable_bit_i && !service_irq_mask_o;
  endsequence
  chk_mask_stops_req: assert property (service_irq_mask_o && $past(service_irq_mask_o)
    |-> !dma_request_o) else $error("request while masked");
  chk_burst_cap: assert property (burst >= 6'h20 |-> !dma_request_o)
    else $error("request beyond 32 cycles");
  chk_tc_sets_mask: assert property (tc_cycle_s |=> service_irq_mask_o ##0 irq_pulse_s)
    else $error("terminal count not handled");
  chk_irq_pulse_len: assert property ($rose(port_irq_out_oe_o) |-> irq_pulse_s)
    else $error("short interrupt pulse");
  chk_push_pull: assert property ($past(rst_n_i) && port_mode_i != 3'h0
    && $past(port_mode_i) != 3'h0 |-> ctl_lines_oe_o == 4'hf) else $error("lines not driven");
  chk_ack_irq: assert property (ack_irq_enable_i && $rose(periph_ack_n_i)
    |-> ##[2:6] port_irq_out_oe_o) else $error("no acknowledge interrupt");
  chk_fault_irq: assert property (!fault_irq_enable_n_i && $fell(periph_fault_n_i)
    |-> ##[2:6] port_irq_out_oe_o) else $error("no fault interrupt");
  chk_unmask_irq: assert property ($fell(service_irq_mask_o) && port_mode_i == 3'h3
    && !direction_i && !dma_enable_bit_i && fifo_empty_o |-> ##[0:3] port_irq_out_oe_o)
    else $error("no interrupt on unmask");
endmodule : ecp_service_monitor

// [ecp_service_pkg.sv]
// Shared constants, encodings and state codes of the ECP FIFO service block.
// Assumes a single 50 MHz clock domain; the gap and pulse counts derive from that rate.
package ecp_service_pkg;

  // Data path widths and FIFO shape
  localparam int          DATA_W        = 8;
  localparam int          ENTRY_W       = 9;
  localparam int          FIFO_DEPTH    = 16;
  localparam int          CNT_W         = 5;
  localparam int          CMD_FLAG_BIT  = 8;
  localparam int          CMD_TYPE_BIT  = 7;
  localparam logic [4:0]  FIFO_FULL_CNT = 5'h10;
  localparam logic [4:0]  THR_MAX_EFF   = 5'h0f;

  // Port mode field codes
  localparam logic [2:0]  MODE_SPP      = 3'h0;
  localparam logic [2:0]  MODE_FIFO     = 3'h2;
  localparam logic [2:0]  MODE_ECP      = 3'h3;

  // Host port offsets, data FIFO and address/run-length FIFO
  localparam logic [10:0] DATA_PORT_OFS = 11'h400;
  localparam logic [10:0] ADDR_PORT_OFS = 11'h000;

  // Control line positions within the four-line group
  localparam int          CTL_STROBE    = 0;
  localparam int          CTL_AUTOFD    = 1;
  localparam int          CTL_INIT      = 2;
  localparam int          CTL_SELIN     = 3;

  // Timing
  localparam int          CLK_PERIOD_NS   = 20;
  localparam int          DACK_GAP_NS     = 350;
  localparam int          IRQ_PULSE_NS    = 100;
  localparam int          DACK_GAP_CYC    = (DACK_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          IRQ_PULSE_CYC   = IRQ_PULSE_NS / CLK_PERIOD_NS;
  localparam logic [4:0]  DACK_GAP_CNT    = 5'(DACK_GAP_CYC);
  localparam logic [2:0]  IRQ_PULSE_CNT   = 3'(IRQ_PULSE_CYC);
  localparam logic [5:0]  DMA_BURST_MAX   = 6'h20;

  // Reset values
  localparam logic        MASK_RST_VAL    = 1'b1;

  // Link sequencer states
  typedef enum logic [6:0] {
    ST_IDLE      = 7'h01,
    ST_FWD_SETUP = 7'h02,
    ST_FWD_STRB  = 7'h04,
    ST_FWD_REL   = 7'h08,
    ST_REV_WAIT  = 7'h10,
    ST_REV_ACK   = 7'h20,
    ST_REV_PUSH  = 7'h40
  } link_state_t;

endpackage : ecp_service_pkg

// [line_sync.sv]
// Two-stage synchroniser for a group of peripheral handshake inputs.
// Assumes the inputs may change at any time relative to ref_clk_i.
`timescale 1ns/1ns
module line_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '1
) (
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  // Lines
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] stage1;

  // First stage feeds only the second stage
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge ref_clk_i)
    begin
      if (!rst_n_i)
      begin
        stage1[i] <= RST_VAL[i];
        sync_o[i] <= RST_VAL[i];
      end
      else
      begin
        stage1[i] <= async_i[i];
        sync_o[i] <= stage1[i];
      end
    end
  end

endmodule : line_sync

// [service_fifo.sv]
// Flop-based FIFO with valid/ready on both sides and an occupancy count.
// Assumes clear is a synchronous flush issued from the owning block.
`timescale 1ns/1ns
module service_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       clear_i,
  // Fill side
  input  wire logic                       in_valid_i,
  output logic                            in_ready_o,
  input  wire logic [WIDTH-1:0]           in_data_i,
  // Drain side
  output logic                            out_valid_o,
  input  wire logic                       out_ready_i,
  output logic      [WIDTH-1:0]           out_data_o,
  // Status
  output logic      [$clog2(DEPTH+1)-1:0] count_o
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr, next_wr_ptr;
  logic [AW-1:0]    rd_ptr, next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             push, pop;

  assign in_ready_o  = (count_o != CW'(DEPTH));
  assign out_valid_o = (count_o != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb
  begin
    next_wr_ptr = push ? AW'((int'(wr_ptr) + 1) % DEPTH) : wr_ptr;
    next_rd_ptr = pop ? AW'((int'(rd_ptr) + 1) % DEPTH) : rd_ptr;
    next_count  = CW'(count_o + CW'(push) - CW'(pop));
    if (clear_i)
    begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      count_o <= '0;
    end
    else
    begin
      wr_ptr  <= next_wr_ptr;
      rd_ptr  <= next_rd_ptr;
      count_o <= next_count;
    end
  end

  // Storage has no reset; out_data_o shows it even when the count is zero
  always_ff @(posedge ref_clk_i)
  begin
    if (push && !clear_i)
      mem[wr_ptr] <= in_data_i;
  end

endmodule : service_fifo

// [tb_top.sv]
// Bench for the ECP FIFO service block: PIO, run-length, DMA and interrupts.
// Assumes a forward-only peripheral model; reverse link traffic is not run.
`timescale 1ns/1ns
module tb_top;
  logic ref_clk_i = 0, rst_n_i = 0, host_wr_i = 0, host_rd_i = 0, dma_tc_i = 0, hold = 0;
  logic dma_acknowledge_n_i = 1, direction_i = 0, dma_enable_bit_i = 0, mask_wr_i = 0;
  logic mask_wdata_i = 0, fault_irq_enable_n_i = 1, ack_irq_enable_i = 0;
  logic periph_ack_n_i = 1, periph_fault_n_i = 1, periph_busy_i;
  logic [10:0] host_addr_i = 11'h000;
  logic [7:0]  host_wdata_i = 8'h00, pat = 8'h00, host_rdata_o, periph_data_o, last;
  logic [2:0]  port_mode_i = 3'h0;
  logic [3:0]  fifo_threshold_field_i = 4'h0, sw_ctl_lines_i = 4'hf;
  logic [3:0]  ctl_lines_o, ctl_lines_oe_o, ctl_wire;
  logic host_wr_ready_o, dma_request_o, service_irq_mask_o, fifo_empty_o, fifo_full_o;
  logic port_irq_out_o, port_irq_out_oe_o, periph_data_oe_o;
  int n_data, n_cmd, err_count = 0, checks_done = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  // Released data lines wander, so a stale value is never mistaken for a good one
  always @(negedge ref_clk_i) pat <= pat + 8'h01;
  assign ctl_wire = (ctl_lines_o & ctl_lines_oe_o) | ~ctl_lines_oe_o;
  ecp_fifo_dma_service i_ecp_fifo_dma_service (.ref_clk_i, .rst_n_i, .host_addr_i,
    .host_wr_i, .host_rd_i, .host_wdata_i, .host_rdata_o, .host_wr_ready_o, .dma_request_o,
    .dma_acknowledge_n_i, .dma_tc_i, .port_mode_i, .direction_i, .dma_enable_bit_i,
    .mask_wr_i, .mask_wdata_i, .service_irq_mask_o, .fault_irq_enable_n_i, .ack_irq_enable_i,
    .fifo_threshold_field_i, .sw_ctl_lines_i, .fifo_empty_o, .fifo_full_o, .port_irq_out_o,
    .port_irq_out_oe_o, .periph_data_o, .periph_data_oe_o, .periph_data_i(pat), .ctl_lines_o,
    .ctl_lines_oe_o, .ctl_lines_i(ctl_wire), .periph_busy_i, .periph_ack_n_i, .periph_fault_n_i);
  ecp_periph_model i_ecp_periph_model (.ref_clk_i, .hold_i(hold), .ctl_i(ctl_wire),
    .data_i(periph_data_o), .busy_o(periph_busy_i), .last_o(last), .n_data_o(n_data),
    .n_cmd_o(n_cmd));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : cyc
  task automatic wt(ref logic s, input int lim);
    int i;
    for (i = 0; i < lim && s !== 1'b1; i++) cyc(1);
    chk("awaited signal", 32'(s), 32'h1);
  endtask : wt
  task automatic hwr(input logic [10:0] a, input logic [7:0] d);
    host_addr_i = a;
    host_wdata_i = d;
    host_wr_i = 1;
    cyc(1);
    host_wr_i = 0;
    cyc(1);
  endtask : hwr
  task automatic msk(input logic b);
    mask_wr_i = 1;
    mask_wdata_i = b;
    cyc(1);
    mask_wr_i = 0;
    cyc(1);
  endtask : msk
  // Address is deliberately junk: the acknowledge alone selects the FIFO
  task automatic dwr(input logic [7:0] d, input logic tc);
    wt(dma_request_o, 100);
    host_addr_i = 11'h123;
    host_wdata_i = d;
    dma_tc_i = tc;
    dma_acknowledge_n_i = 0;
    host_wr_i = 1;
    cyc(1);
    dma_acknowledge_n_i = 1;
    host_wr_i = 0;
    dma_tc_i = 0;
    cyc(1);
  endtask : dwr
  task automatic tally_and_finish;
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    cyc(20000);
    err_count++;
    tally_and_finish();
  end
  initial
  begin
    cyc(10);
    rst_n_i = 1;
    cyc(2);
    chk("mask", 32'(service_irq_mask_o), 32'h1);
    hwr(ecp_service_pkg::DATA_PORT_OFS, 8'h11);
    chk("spp empty", 32'(fifo_empty_o), 32'h1);
    port_mode_i = ecp_service_pkg::MODE_ECP;
    hwr(ecp_service_pkg::DATA_PORT_OFS, 8'h22);
    hwr(ecp_service_pkg::DATA_PORT_OFS, 8'h22);
    hwr(ecp_service_pkg::ADDR_PORT_OFS, 8'h03);
    hwr(ecp_service_pkg::DATA_PORT_OFS, 8'h5a);
    hwr(ecp_service_pkg::ADDR_PORT_OFS, 8'h85);
    cyc(150);
    chk("data bytes", n_data, 6);
    chk("commands", n_cmd, 1);
    chk("last", 32'(last), 32'h85);
    hold = 1;
    repeat (18) hwr(ecp_service_pkg::DATA_PORT_OFS, 8'h33);
    chk("full", 32'(fifo_full_o), 32'h1);
    chk("ready", 32'(host_wr_ready_o), 32'h0);
    fifo_threshold_field_i = 4'hf;
    msk(0);
    cyc(6);
    chk("irq at 16", 32'(port_irq_out_oe_o), 32'h0);
    hold = 0;
    wt(port_irq_out_oe_o, 60);
    cyc(400);
    chk("drained", n_data, 23);
    chk("empty", 32'(fifo_empty_o), 32'h1);
    msk(1);
    cyc(8);
    chk("masked irq", 32'(port_irq_out_oe_o), 32'h0);
    msk(0);
    wt(port_irq_out_oe_o, 6);
    ack_irq_enable_i = 1;
    periph_ack_n_i = 0;
    cyc(10);
    periph_ack_n_i = 1;
    wt(port_irq_out_oe_o, 8);
    fault_irq_enable_n_i = 0;
    cyc(10);
    periph_fault_n_i = 0;
    wt(port_irq_out_oe_o, 8);
    fault_irq_enable_n_i = 1;
    cyc(10);
    fault_irq_enable_n_i = 0;
    wt(port_irq_out_oe_o, 8);
    periph_fault_n_i = 1;
    msk(1);
    dma_enable_bit_i = 1;
    msk(0);
    repeat (31)
    begin
      dwr(8'h44, 0);
      wt(fifo_empty_o, 40);
    end
    dwr(8'h44, 0);
    repeat (17)
    begin
      chk("burst gap", 32'(dma_request_o), 32'h0);
      cyc(1);
    end
    dwr(8'h77, 1);
    chk("tc mask", 32'(service_irq_mask_o), 32'h1);
    chk("tc irq", 32'(port_irq_out_oe_o), 32'h1);
    rst_n_i = 0;
    cyc(3);
    rst_n_i = 1;
    cyc(2);
    chk("reset empty", 32'(fifo_empty_o), 32'h1);
    tally_and_finish();
  end
endmodule : tb_top
bind ecp_fifo_dma_service ecp_service_monitor i_ecp_service_monitor (.ref_clk_i, .rst_n_i,
  .host_wr_i, .host_rd_i, .dma_request_o, .dma_acknowledge_n_i, .dma_tc_i, .port_mode_i,
  .direction_i, .dma_enable_bit_i, .service_irq_mask_o, .fifo_empty_o, .fault_irq_enable_n_i,
  .ack_irq_enable_i, .periph_ack_n_i, .periph_fault_n_i, .port_irq_out_oe_o, .ctl_lines_oe_o);
